// file: rtl/peak_agc_pkg.sv
package peak_agc_pkg;
  // Widths
  localparam int SAMPLE_W = 16;
  localparam int POWER_W = 32;
  localparam int CODE_W = 12;
  localparam int REG_W = 8;
  localparam int IDX_W = 10;
  localparam int PIN_N = 4;
  localparam int DWELL_W = 24;
  localparam int BUS_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ATT_MODE = 10'h180;
  localparam logic [IDX_W-1:0] IDX_ATT_LEVEL_A = 10'h181;
  localparam logic [IDX_W-1:0] IDX_ATT_LEVEL_B = 10'h182;
  localparam logic [IDX_W-1:0] IDX_ATT_START = 10'h183;
  localparam logic [IDX_W-1:0] IDX_ATT_READBACK = 10'h184;
  localparam logic [IDX_W-1:0] IDX_UPPER_A_MSB = 10'h193;
  localparam logic [IDX_W-1:0] IDX_UPPER_A_LSB = 10'h194;
  localparam logic [IDX_W-1:0] IDX_UPPER_B_MSB = 10'h195;
  localparam logic [IDX_W-1:0] IDX_UPPER_B_LSB = 10'h196;
  localparam logic [IDX_W-1:0] IDX_LOWER_MSB = 10'h197;
  localparam logic [IDX_W-1:0] IDX_LOWER_LSB = 10'h198;
  localparam logic [IDX_W-1:0] IDX_DWELL_MANT = 10'h199;
  localparam logic [IDX_W-1:0] IDX_DWELL_EXP = 10'h19A;
  localparam logic [IDX_W-1:0] IDX_FLAG_A_SRC = 10'h19B;
  localparam logic [IDX_W-1:0] IDX_FLAG_B_SRC = 10'h19C;
  localparam logic [IDX_W-1:0] IDX_FLAG_EN = 10'h19D;
  localparam logic [IDX_W-1:0] IDX_DEC_SETTING = 10'h19E;
  localparam logic [IDX_W-1:0] IDX_GPIO_SEL = 10'h1B0;
  localparam logic [IDX_W-1:0] IDX_GPIO_DIR = 10'h1B1;
  localparam logic [IDX_W-1:0] IDX_GPIO_LEVEL = 10'h1B2;
  localparam logic [IDX_W-1:0] IDX_GPIO_OUT_RB = 10'h1B3;
  localparam logic [IDX_W-1:0] IDX_GPIO_IN_RB = 10'h1B4;

  // Field positions
  localparam int MODE_STEP_BIT = 0;
  localparam int EN_A_BIT = 0;
  localparam int EN_B_BIT = 1;
  localparam int OR_A_BIT = 2;
  localparam int OR_B_BIT = 3;
  localparam int PIN_UP = 0;
  localparam int PIN_DOWN = 1;
  localparam int PIN_FLAG_A = 2;
  localparam int PIN_FLAG_B = 3;

  // Reset values
  localparam logic [REG_W-1:0] ATT_LEVEL_RESET = 8'h0C;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] THR_RESET = 12'h000;

  // Power to code mapping
  localparam int ZERO_DBFS_CODE = 12'hE00;
  localparam int FULL_SCALE_EXP = 30;
  localparam int CODE_PER_OCTAVE = 256;
  localparam int CODE_MAX = 12'hFFF;

  // Flag sources and decimation settings
  localparam logic [1:0] SRC_UPPER_A = 2'h0;
  localparam logic [1:0] SRC_UPPER_B = 2'h1;
  localparam logic [1:0] SRC_LOWER = 2'h2;
  localparam logic [1:0] SRC_ADC_RESET = 2'h3;
  localparam logic [2:0] DEC_32 = 3'h1;
  localparam logic [2:0] DEC_24 = 3'h2;

  // AHB-Lite
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// file: rtl/peak_detect_agc_flags.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module peak_detect_agc_flags #(
  parameter logic [7:0] ATTEN_MAX = 8'h1F
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic clkEn, // Freezes all state when low
  input wire logic hsel, // AHB slave select
  input wire logic [peak_agc_pkg::BUS_W-1:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [peak_agc_pkg::BUS_W-1:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [peak_agc_pkg::BUS_W-1:0] hrdata, // AHB read data
  input wire logic signed [peak_agc_pkg::SAMPLE_W-1:0] iSample, // Detector I sample
  input wire logic signed [peak_agc_pkg::SAMPLE_W-1:0] qSample, // Detector Q sample
  input wire logic sampleValid, // Detector sample strobe
  input wire logic outSampleStrobe, // Output IQ sample strobe
  input wire logic adcResetEvent, // Modulator reset event pulse
  input wire logic [peak_agc_pkg::PIN_N-1:0] pinIn, // Control pin levels
  output logic [peak_agc_pkg::PIN_N-1:0] pinOut, // Control pin drive level
  output logic [peak_agc_pkg::PIN_N-1:0] pinOeN, // Control pin enable, low drives
  output logic [peak_agc_pkg::REG_W-1:0] attenSetting // Attenuator value in force
);
  import peak_agc_pkg::*;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DATA} busState_type;

  busState_type busState_r;
  logic [IDX_W-1:0] addrIdx_r;
  logic [BUS_W-1:0] hrdata_r;
  logic [REG_W-1:0] regRead;
  logic accept;
  logic regWrite;

  logic [REG_W-1:0] attMode_r, attLevelA_r, attLevelB_r, attStart_r;
  logic [REG_W-1:0] gpioSel_r, gpioDir_r, gpioLevel_r;
  logic [CODE_W-1:0] thrUpperA_r, thrUpperB_r, thrLower_r;
  logic [REG_W-1:0] dwellMant_r, dwellExp_r, flagEn_r, decSetting_r;
  logic [1:0] flagASrc_r, flagBSrc_r;

  logic [POWER_W-1:0] power_r;
  logic powValid_r;
  logic [CODE_W-1:0] code_r;
  logic codeValid_r;
  logic aboveA_r, aboveB_r;
  logic [DWELL_W-1:0] dwellCnt_r;
  logic [DWELL_W-1:0] dwellTarget;
  logic dwellPhase_r;
  logic lowFlag_r;
  logic resetPend_r;
  logic [1:0] resetStage_r;
  logic resetFlag;
  logic shortLat;
  logic flagA_r, flagB_r;

  logic [PIN_N-1:0] pinSync1_r, pinSync2_r, pinPrev_r;
  logic upEdge, downEdge, stepMode, loadPend_r;
  logic [REG_W-1:0] attenValue_r;
  logic [PIN_N-1:0] pinFlag, pinFlagEn, gpioOutRb, gpioInRb;

  function automatic logic [CODE_W-1:0] powerToCode(input logic [POWER_W-1:0] p);
    int msb;
    int codeInt;
    logic [POWER_W-1:0] norm;
    msb = 0;
    for (int k = 0; k < POWER_W; k++)
    begin
      if (p[k])
        msb = k;
    end
    norm = p << (POWER_W - 1 - msb);
    codeInt = ZERO_DBFS_CODE + (msb - FULL_SCALE_EXP) * CODE_PER_OCTAVE + int'(norm[POWER_W-2 -: 8]);
    if (p == '0 || codeInt < 0)
      codeInt = 0;
    else if (codeInt > CODE_MAX)
      codeInt = CODE_MAX;
    return CODE_W'(codeInt);
  endfunction

  // Widen before squaring so the product keeps all its bits
  function automatic logic [POWER_W-1:0] square(input logic signed [SAMPLE_W-1:0] s);
    logic signed [POWER_W-1:0] w;
    w = POWER_W'(s);
    return POWER_W'(w * w);
  endfunction

  function automatic logic selectFlag(input logic [1:0] src, input logic orReset, input logic upA,
                                      input logic upB, input logic low, input logic rst);
    case (src)
      SRC_UPPER_A: return upA | (orReset & rst);
      SRC_UPPER_B: return upB | (orReset & rst);
      SRC_LOWER: return low;
      default: return rst;
    endcase
  endfunction

  // Bus slave: writes take no wait state, reads take one
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
  assign regWrite = clkEn && busState_r == BUS_WRITE;
  assign hreadyout = busState_r != BUS_READ_WAIT;
  assign hresp = 1'h0;
  assign hrdata = hrdata_r;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      busState_r <= BUS_IDLE;
      addrIdx_r <= '0;
    end
    else if (clkEn)
    begin
      if (accept)
      begin
        busState_r <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
        addrIdx_r <= (haddr[BUS_W-1:IDX_W+2] == '0) ? haddr[IDX_W+1:2] : '0;
      end
      else if (busState_r == BUS_READ_WAIT)
        busState_r <= BUS_READ_DATA;
      else
        busState_r <= BUS_IDLE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      hrdata_r <= '0;
    else if (clkEn && busState_r == BUS_READ_WAIT)
      hrdata_r <= {{(BUS_W - REG_W){1'h0}}, regRead};
  end

  always_comb
  begin
    case (addrIdx_r)
      IDX_ATT_MODE: regRead = attMode_r;
      IDX_ATT_LEVEL_A: regRead = attLevelA_r;
      IDX_ATT_LEVEL_B: regRead = attLevelB_r;
      IDX_ATT_START: regRead = attStart_r;
      IDX_ATT_READBACK: regRead = attenValue_r;
      IDX_UPPER_A_MSB: regRead = {4'h0, thrUpperA_r[11:8]};
      IDX_UPPER_A_LSB: regRead = thrUpperA_r[7:0];
      IDX_UPPER_B_MSB: regRead = {4'h0, thrUpperB_r[11:8]};
      IDX_UPPER_B_LSB: regRead = thrUpperB_r[7:0];
      IDX_LOWER_MSB: regRead = {4'h0, thrLower_r[11:8]};
      IDX_LOWER_LSB: regRead = thrLower_r[7:0];
      IDX_DWELL_MANT: regRead = dwellMant_r;
      IDX_DWELL_EXP: regRead = dwellExp_r;
      IDX_FLAG_A_SRC: regRead = {6'h00, flagASrc_r};
      IDX_FLAG_B_SRC: regRead = {6'h00, flagBSrc_r};
      IDX_FLAG_EN: regRead = flagEn_r;
      IDX_DEC_SETTING: regRead = decSetting_r;
      IDX_GPIO_SEL: regRead = gpioSel_r;
      IDX_GPIO_DIR: regRead = gpioDir_r;
      IDX_GPIO_LEVEL: regRead = gpioLevel_r;
      IDX_GPIO_OUT_RB: regRead = {4'h0, gpioOutRb};
      IDX_GPIO_IN_RB: regRead = {4'h0, gpioInRb};
      default: regRead = REG_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      attMode_r <= REG_ZERO;
      attLevelA_r <= ATT_LEVEL_RESET;
      attLevelB_r <= ATT_LEVEL_RESET;
      attStart_r <= REG_ZERO;
      gpioSel_r <= REG_ZERO;
      gpioDir_r <= REG_ZERO;
      gpioLevel_r <= REG_ZERO;
      thrUpperA_r <= THR_RESET;
      thrUpperB_r <= THR_RESET;
      thrLower_r <= THR_RESET;
      dwellMant_r <= REG_ZERO;
      dwellExp_r <= REG_ZERO;
      flagASrc_r <= SRC_UPPER_A;
      flagBSrc_r <= SRC_UPPER_A;
      flagEn_r <= REG_ZERO;
      decSetting_r <= REG_ZERO;
    end
    else if (regWrite)
    begin
      case (addrIdx_r)
        IDX_ATT_MODE: attMode_r <= {7'h00, hwdata[MODE_STEP_BIT]};
        IDX_ATT_LEVEL_A: attLevelA_r <= hwdata[7:0];
        IDX_ATT_LEVEL_B: attLevelB_r <= hwdata[7:0];
        IDX_ATT_START: attStart_r <= hwdata[7:0];
        IDX_UPPER_A_MSB: thrUpperA_r[11:8] <= hwdata[3:0];
        IDX_UPPER_A_LSB: thrUpperA_r[7:0] <= hwdata[7:0];
        IDX_UPPER_B_MSB: thrUpperB_r[11:8] <= hwdata[3:0];
        IDX_UPPER_B_LSB: thrUpperB_r[7:0] <= hwdata[7:0];
        IDX_LOWER_MSB: thrLower_r[11:8] <= hwdata[3:0];
        IDX_LOWER_LSB: thrLower_r[7:0] <= hwdata[7:0];
        IDX_DWELL_MANT: dwellMant_r <= hwdata[7:0];
        IDX_DWELL_EXP: dwellExp_r <= {4'h0, hwdata[3:0]};
        IDX_FLAG_A_SRC: flagASrc_r <= hwdata[1:0];
        IDX_FLAG_B_SRC: flagBSrc_r <= hwdata[1:0];
        IDX_FLAG_EN: flagEn_r <= {4'h0, hwdata[3:0]};
        IDX_DEC_SETTING: decSetting_r <= {5'h00, hwdata[2:0]};
        IDX_GPIO_SEL: gpioSel_r <= {4'h0, hwdata[3:0]};
        IDX_GPIO_DIR: gpioDir_r <= {4'h0, hwdata[3:0]};
        IDX_GPIO_LEVEL: gpioLevel_r <= {4'h0, hwdata[3:0]};
        default: ;
      endcase
    end
  end

  // Power of each zero-IF detector sample, then log code
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      power_r <= '0;
      powValid_r <= 1'h0;
      code_r <= '0;
      codeValid_r <= 1'h0;
    end
    else if (clkEn)
    begin
      powValid_r <= sampleValid;
      codeValid_r <= powValid_r;
      if (sampleValid)
        power_r <= square(iSample) + square(qSample);
      if (powValid_r)
        code_r <= powerToCode(power_r);
    end
  end

  // Threshold compare every detector sample
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      aboveA_r <= 1'h0;
      aboveB_r <= 1'h0;
    end
    else if (clkEn && codeValid_r)
    begin
      aboveA_r <= code_r > thrUpperA_r;
      aboveB_r <= code_r > thrUpperB_r;
    end
  end

  // Dwell ticks every second detector sample, i.e. ADC/12 or ADC/16
  assign dwellTarget = DWELL_W'({16'h0000, dwellMant_r} << dwellExp_r[3:0]);

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      dwellCnt_r <= '0;
      dwellPhase_r <= 1'h0;
      lowFlag_r <= 1'h0;
    end
    else if (clkEn && codeValid_r)
    begin
      if (code_r > thrLower_r)
      begin
        dwellCnt_r <= '0;
        dwellPhase_r <= 1'h0;
        lowFlag_r <= 1'h0;
      end
      else
      begin
        dwellPhase_r <= ~dwellPhase_r;
        if (dwellPhase_r && dwellCnt_r < dwellTarget)
          dwellCnt_r <= dwellCnt_r + 1'h1;
        lowFlag_r <= dwellCnt_r >= dwellTarget;
      end
    end
  end

  // Reset event skips the filter path, counted in output samples
  assign shortLat = decSetting_r[2:0] == DEC_32 || decSetting_r[2:0] == DEC_24;
  assign resetFlag = shortLat ? resetStage_r[0] : resetStage_r[1];

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      resetPend_r <= 1'h0;
      resetStage_r <= 2'h0;
    end
    else if (clkEn)
    begin
      if (outSampleStrobe)
      begin
        resetStage_r <= {resetStage_r[0], resetPend_r};
        resetPend_r <= adcResetEvent;
      end
      else if (adcResetEvent)
        resetPend_r <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      flagA_r <= 1'h0;
      flagB_r <= 1'h0;
    end
    else if (clkEn)
    begin
      flagA_r <= selectFlag(flagASrc_r, flagEn_r[OR_A_BIT], aboveA_r, aboveB_r, lowFlag_r, resetFlag);
      flagB_r <= selectFlag(flagBSrc_r, flagEn_r[OR_B_BIT], aboveA_r, aboveB_r, lowFlag_r, resetFlag);
    end
  end

  // Pin synchroniser and edge history
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pinSync1_r <= '0;
      pinSync2_r <= '0;
      pinPrev_r <= '0;
    end
    else if (clkEn)
    begin
      pinSync1_r <= pinIn;
      pinSync2_r <= pinSync1_r;
      pinPrev_r <= pinSync2_r;
    end
  end

  assign upEdge = pinSync2_r[PIN_UP] & ~pinPrev_r[PIN_UP] & ~gpioSel_r[PIN_UP];
  assign downEdge = pinSync2_r[PIN_DOWN] & ~pinPrev_r[PIN_DOWN] & ~gpioSel_r[PIN_DOWN];
  assign stepMode = attMode_r[MODE_STEP_BIT];

  // Attenuator in force
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      attenValue_r <= ATT_LEVEL_RESET;
      loadPend_r <= 1'h0;
    end
    else if (clkEn)
    begin
      loadPend_r <= regWrite && (addrIdx_r == IDX_ATT_MODE || addrIdx_r == IDX_ATT_START);
      if (!stepMode)
        attenValue_r <= (pinSync2_r[PIN_DOWN] & ~gpioSel_r[PIN_DOWN]) ? attLevelB_r : attLevelA_r;
      else if (loadPend_r)
        attenValue_r <= attStart_r;
      else if (downEdge && !upEdge && attenValue_r != REG_ZERO)
        attenValue_r <= attenValue_r - 8'h01;
      else if (upEdge && !downEdge && attenValue_r < ATTEN_MAX)
        attenValue_r <= attenValue_r + 8'h01;
    end
  end

  assign attenSetting = attenValue_r;

  // Pin drivers
  assign pinFlag = {flagB_r, flagA_r, 2'h0};
  assign pinFlagEn = {flagEn_r[EN_B_BIT], flagEn_r[EN_A_BIT], 2'h0};
  assign gpioOutRb = gpioLevel_r[PIN_N-1:0] & gpioSel_r[PIN_N-1:0] & gpioDir_r[PIN_N-1:0];
  assign gpioInRb = pinSync2_r & gpioSel_r[PIN_N-1:0] & ~gpioDir_r[PIN_N-1:0];

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_pin
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
        begin
          pinOut[g] <= 1'h0;
          pinOeN[g] <= 1'h1;
        end
        else if (clkEn)
        begin
          if (gpioSel_r[g])
          begin
            pinOut[g] <= gpioLevel_r[g];
            pinOeN[g] <= ~gpioDir_r[g];
          end
          else
          begin
            pinOut[g] <= pinFlag[g] & pinFlagEn[g];
            pinOeN[g] <= ~pinFlagEn[g];
          end
        end
      end
    end
  endgenerate

  a_upper_exceed: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && codeValid_r && code_r <= thrUpperB_r |=> !aboveB_r)
    else $error("upper flag set without exceeding threshold");

  a_dwell_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && codeValid_r && code_r > thrLower_r |=> dwellCnt_r == '0 && !lowFlag_r)
    else $error("dwell not restarted on excursion");

  a_dwell_expiry: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(lowFlag_r) |-> $past(dwellCnt_r) >= $past(dwellTarget))
    else $error("lower flag rose before dwell expired");

  a_flag_pin_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && !gpioSel_r[PIN_FLAG_A] && !flagEn_r[EN_A_BIT] |=> pinOeN[PIN_FLAG_A] && !pinOut[PIN_FLAG_A])
    else $error("disabled flag pin driven");

  a_reset_bypass: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && outSampleStrobe && resetStage_r[0] && !shortLat |=> resetFlag)
    else $error("reset flag not raised after two output samples");

  a_two_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && !stepMode && !gpioSel_r[PIN_DOWN] && pinSync2_r[PIN_DOWN] |=> attenValue_r == $past(attLevelB_r))
    else $error("two-level mode ignored down pin");

  a_step_down: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && stepMode && !loadPend_r && downEdge && !upEdge && attenValue_r != REG_ZERO
    |=> attenValue_r == $past(attenValue_r) - 8'h01)
    else $error("down pulse did not lower attenuation by one");

  a_step_saturate: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && stepMode && !loadPend_r && attenValue_r == ATTEN_MAX && upEdge && !downEdge |=> attenValue_r == ATTEN_MAX)
    else $error("step attenuation wrapped");

  a_reset_state: assert property (@(posedge clk_sys) disable iff (!nrst)
    nrst && !$past(nrst) |-> attenValue_r == ATT_LEVEL_RESET && !stepMode)
    else $error("wrong attenuator state after reset");

  a_gpio_output: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && gpioSel_r[PIN_FLAG_B] && gpioDir_r[PIN_FLAG_B]
    |=> !pinOeN[PIN_FLAG_B] && pinOut[PIN_FLAG_B] == $past(gpioLevel_r[PIN_FLAG_B]))
    else $error("gpio output not driven");
endmodule

// file: sim/host_agc_model.sv
`timescale 1ns/100ps
module host_agc_model (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic upCmd, // Request one raise step
  input wire logic downCmd, // Request one lower step
  input wire logic holdLevel, // Two-level select level
  output logic upPin, // Attenuator up pin drive
  output logic downPin // Attenuator down pin drive
);
  logic [1:0] upCnt_r;
  logic [1:0] downCnt_r;
  // Two-clock pulses so the device synchroniser sees each one
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      upCnt_r <= 2'h0;
      downCnt_r <= 2'h0;
    end
    else
    begin
      upCnt_r <= upCmd ? 2'h2 : (upCnt_r != 2'h0 ? upCnt_r - 2'h1 : 2'h0);
      downCnt_r <= downCmd ? 2'h2 : (downCnt_r != 2'h0 ? downCnt_r - 2'h1 : 2'h0);
    end
  end
  assign upPin = upCnt_r != 2'h0;
  assign downPin = (downCnt_r != 2'h0) | holdLevel;
endmodule

// file: sim/peak_detect_agc_flags_tb.sv
`timescale 1ns/100ps
module peak_detect_agc_flags_tb;
  import peak_agc_pkg::*;
  logic clk_sys, nrst, clkEn, hsel, hwrite, hreadyout, hresp, sampleValid, outSampleStrobe, adcResetEvent;
  logic upCmd, downCmd, holdLevel, upPin, downPin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic signed [15:0] iSample, qSample;
  logic [3:0] pinOut, pinOeN, pad;
  logic [7:0] attenSetting;
  int bad_count = 0;
  int samples_checked = 0;

  peak_detect_agc_flags peak_detect_agc_flags_i (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .iSample(iSample), .qSample(qSample),
    .sampleValid(sampleValid), .outSampleStrobe(outSampleStrobe), .adcResetEvent(adcResetEvent),
    .pinIn(pad), .pinOut(pinOut), .pinOeN(pinOeN), .attenSetting(attenSetting));
  host_agc_model host_agc_model_i (.clk_sys(clk_sys), .nrst(nrst), .upCmd(upCmd), .downCmd(downCmd),
    .holdLevel(holdLevel), .upPin(upPin), .downPin(downPin));
  // Flag pins have pull-downs when undriven
  assign pad = {~pinOeN[3] & pinOut[3], ~pinOeN[2] & pinOut[2], pinOeN[1] ? downPin : pinOut[1],
    pinOeN[0] ? upPin : pinOut[0]};

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic ahbXfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] r;
    ahbXfer(1'b1, idx, {24'h0, d}, r);
  endtask

  task automatic rdChk(input logic [IDX_W-1:0] idx, input logic [7:0] e, input string msg);
    logic [31:0] r;
    ahbXfer(1'b0, idx, 32'h0, r);
    check(r, {24'h0, e}, msg);
  endtask

  function automatic logic [11:0] thrCode(input int dbfs);
    return 12'(3584 + dbfs * 256 / 3);
  endfunction

  task automatic setThr(input logic [IDX_W-1:0] msb, input logic [11:0] code);
    wr(msb, {4'h0, code[11:8]});
    wr(msb + 10'h1, code[7:0]);
  endtask

  task automatic sample(input logic signed [15:0] i, input logic signed [15:0] q, input int n);
    repeat (n)
    begin
      iSample <= i;
      qSample <= q;
      sampleValid <= 1'b1;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  task automatic strobe();
    outSampleStrobe <= 1'b1;
    @(posedge clk_sys);
    outSampleStrobe <= 1'b0;
    waitClk(3);
  endtask

  task automatic step(input logic up, input logic [7:0] e);
    if (up)
      upCmd <= 1'b1;
    else
      downCmd <= 1'b1;
    @(posedge clk_sys);
    upCmd <= 1'b0;
    downCmd <= 1'b0;
    waitClk(8);
    check(attenSetting, e, "step");
  endtask

  task automatic testReset();
    check(attenSetting, ATT_LEVEL_RESET, "reset atten");
    check(pinOeN, 4'hF, "reset pins");
    check(hresp, 1'b0, "okay");
    rdChk(IDX_ATT_MODE, 8'h00, "mode");
    rdChk(IDX_ATT_LEVEL_A, 8'h0C, "level a");
    rdChk(IDX_ATT_LEVEL_B, 8'h0C, "level b");
    rdChk(10'h3FF, 8'h00, "unmapped");
    holdLevel <= 1'b1;
    waitClk(6);
    check(attenSetting, 8'h0C, "pin independent");
    holdLevel <= 1'b0;
  endtask

  task automatic testTwoLevel();
    wr(IDX_ATT_LEVEL_A, 8'h05);
    wr(IDX_ATT_LEVEL_B, 8'h11);
    waitClk(5);
    check(attenSetting, 8'h05, "level a");
    rdChk(IDX_ATT_READBACK, 8'h05, "readback a");
    holdLevel <= 1'b1;
    waitClk(5);
    check(attenSetting, 8'h11, "level b");
    rdChk(IDX_ATT_READBACK, 8'h11, "readback b");
    holdLevel <= 1'b0;
  endtask

  task automatic testFreeze();
    waitClk(5);
    clkEn <= 1'b0;
    holdLevel <= 1'b1;
    waitClk(5);
    check(attenSetting, 8'h05, "frozen");
    clkEn <= 1'b1;
    waitClk(5);
    check(attenSetting, 8'h11, "thawed");
    holdLevel <= 1'b0;
    waitClk(5);
  endtask

  task automatic testStep();
    wr(IDX_ATT_MODE, 8'h01);
    wr(IDX_ATT_START, 8'h1E);
    rdChk(IDX_ATT_MODE, 8'h01, "mode step");
    check(attenSetting, 8'h1E, "start");
    step(1'b1, 8'h1F);
    step(1'b1, 8'h1F);
    step(1'b0, 8'h1E);
    wr(IDX_ATT_START, 8'h01);
    waitClk(4);
    step(1'b0, 8'h00);
    step(1'b0, 8'h00);
    rdChk(IDX_ATT_READBACK, 8'h00, "readback step");
    wr(IDX_ATT_MODE, 8'h00);
  endtask

  task automatic testUpper();
    wr(IDX_FLAG_A_SRC, {6'h0, SRC_UPPER_A});
    wr(IDX_FLAG_B_SRC, {6'h0, SRC_UPPER_B});
    setThr(IDX_UPPER_A_MSB, thrCode(-6));
    setThr(IDX_UPPER_B_MSB, thrCode(-9));
    wr(IDX_FLAG_EN, 8'h03);
    sample(16'sh0, 16'sh4000, 1);
    waitClk(6);
    check(pad[2], 1'b0, "equal code");
    check(pad[3], 1'b1, "upper b");
    check(pinOeN[3:2], 2'h0, "flags driven");
    setThr(IDX_UPPER_A_MSB, thrCode(-9));
    sample(16'sh4000, 16'sh0, 1);
    waitClk(6);
    check(pad[2], 1'b1, "upper a");
    sample(16'sh0, 16'sh0, 1);
    waitClk(6);
    check(pad[3:2], 2'h0, "fall back");
    wr(IDX_FLAG_EN, 8'h00);
    waitClk(2);
    check(pinOeN[3:2], 2'h3, "disabled");
  endtask

  task automatic testLower();
    wr(IDX_FLAG_B_SRC, {6'h0, SRC_LOWER});
    setThr(IDX_LOWER_MSB, thrCode(-6));
    wr(IDX_DWELL_MANT, 8'h02);
    wr(IDX_DWELL_EXP, 8'h01);
    wr(IDX_DEC_SETTING, {5'h0, DEC_32});
    wr(IDX_FLAG_EN, 8'h02);
    sample(16'sh7FFF, 16'sh0, 1);
    sample(16'sh0, 16'sh0, 4);
    waitClk(6);
    check(pad[3], 1'b0, "dwell early");
    sample(16'sh7FFF, 16'sh0, 1);
    sample(16'sh0, 16'sh0, 6);
    waitClk(6);
    check(pad[3], 1'b0, "dwell restart");
    sample(16'sh0, 16'sh0, 4);
    waitClk(6);
    check(pad[3], 1'b1, "dwell done");
  endtask

  task automatic testResetEvent();
    wr(IDX_FLAG_A_SRC, {6'h0, SRC_ADC_RESET});
    wr(IDX_FLAG_B_SRC, {6'h0, SRC_UPPER_B});
    setThr(IDX_UPPER_B_MSB, 12'hFFF);
    wr(IDX_FLAG_EN, 8'h0B);
    for (int d = 1; d <= 4; d++)
    begin
      wr(IDX_DEC_SETTING, 8'(d));
      adcResetEvent <= 1'b1;
      @(posedge clk_sys);
      adcResetEvent <= 1'b0;
      @(posedge clk_sys);
      strobe();
      check(pad[2], d <= 2, "event first");
      check(pad[3], d <= 2, "event or");
      strobe();
      check(pad[2], d > 2, "event second");
      strobe();
    end
    wr(IDX_FLAG_EN, 8'h00);
  endtask

  task automatic testGpio();
    wr(IDX_GPIO_SEL, 8'h0A);
    wr(IDX_GPIO_DIR, 8'h08);
    wr(IDX_GPIO_LEVEL, 8'h08);
    waitClk(3);
    check({pinOeN[3], pad[3]}, 2'h1, "gpio out");
    rdChk(IDX_GPIO_OUT_RB, 8'h08, "out readback");
    holdLevel <= 1'b1;
    waitClk(4);
    rdChk(IDX_GPIO_IN_RB, 8'h02, "in readback");
    wr(IDX_GPIO_LEVEL, 8'h00);
    waitClk(3);
    check(pad[3], 1'b0, "gpio low");
  endtask

  initial
  begin
    #(50 * 20000);
    bad_count++;
    results();
  end

  initial
  begin
    nrst = 1'b0;
    clkEn = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    iSample = 16'sh0;
    qSample = 16'sh0;
    sampleValid = 1'b0;
    outSampleStrobe = 1'b0;
    adcResetEvent = 1'b0;
    upCmd = 1'b0;
    downCmd = 1'b0;
    holdLevel = 1'b0;
    waitClk(2);
    nrst <= 1'b1;
    @(posedge clk_sys);
    testReset();
    testTwoLevel();
    testFreeze();
    testStep();
    testUpper();
    testLower();
    testResetEvent();
    testGpio();
    results();
  end
endmodule
